// file: rtl/rio_image_pkg.sv
// Purpose: shared constants for the remote I/O input image assembler
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses; field positions and reset values below
package rio_image_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_SEL      = 8'h04;
    localparam logic [7:0] OFS_TAG_CNT  = 8'h08;
    localparam logic [7:0] OFS_TAG_SIZE = 8'h0C;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // control register fields
    localparam int CTRL_GEN_SEL     = 0;
    localparam int CTRL_OUT_STAT    = 1;
    localparam int CTRL_OUT_MON     = 2;
    localparam int CTRL_IN_USED     = 3;
    localparam int CTRL_OUT_USED    = 4;
    localparam int CTRL_W           = 5;

    // selection register field positions
    localparam int SEL_IN_STAT_LSB  = 0;
    localparam int SEL_TEST_LSB     = 8;
    localparam int SEL_IN_MON_LSB   = 16;

    // status register field positions
    localparam int STAT_GEN_LSB     = 0;
    localparam int STAT_LEN_LSB     = 8;
    localparam int STAT_OVF_BIT     = 16;

    // general status bit positions
    localparam int GS_IN_PWR        = 0;
    localparam int GS_OUT_PWR       = 1;
    localparam int GS_STD_ERR       = 2;

    // interrupt event bits
    localparam int IRQ_IN_PWR       = 0;
    localparam int IRQ_OUT_PWR      = 1;
    localparam int IRQ_STD_ERR      = 2;
    localparam int IRQ_OVF          = 3;
    localparam int IRQ_W            = 4;

    // tag size codes, two bits per tag
    localparam logic [1:0] TSZ_BYTE  = 2'h0;
    localparam logic [1:0] TSZ_WORD  = 2'h1;
    localparam logic [1:0] TSZ_DWORD = 2'h2;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST     = 5'h00;
    localparam logic [31:0]       SEL_RST      = 32'h0000_0000;
    localparam logic [IRQ_W-1:0]  IRQ_MASK_RST = 4'h0;

endpackage

// file: rtl/gen_status_unit.sv
// Purpose: low three bits of the general status byte
// Assumes: fault and link inputs synchronous to clock
// Notes:   upper five bits are outside this block and read as zero
`timescale 1ns/1ps
module gen_status_unit #(
    parameter int NETS = 2
) (
    input  wire logic            clock,
    input  wire logic            nrst,
    input  wire logic            in_pwr_fault,
    input  wire logic            in_used,
    input  wire logic            out_pwr_fault,
    input  wire logic            out_used,
    input  wire logic [NETS-1:0] std_conn_est,
    input  wire logic [NETS-1:0] std_conn_err,
    output logic      [7:0]      gen_status_r
);
    import rio_image_pkg::*;

    logic [7:0] gen_status_nxt;

    // an unestablished network cannot report an error, so gate by establishment
    always_comb begin
        gen_status_nxt             = 8'h00;
        gen_status_nxt[GS_IN_PWR]  = in_pwr_fault & in_used;
        gen_status_nxt[GS_OUT_PWR] = out_pwr_fault & out_used;
        gen_status_nxt[GS_STD_ERR] = |(std_conn_est & std_conn_err);
    end

    // recomputed every cycle, zero while in reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gen_status_r <= 8'h00;
        end else begin
            gen_status_r <= gen_status_nxt;
        end
    end

endmodule

// file: rtl/rio_image_assembler.sv
// Purpose: packs selected status, monitor bytes and tags into the remote I/O image
// Assumes: all data inputs synchronous to clock; APB master per AMBA APB
// Notes:   image is rebuilt every cycle; general status arrives one cycle late
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module rio_image_assembler #(
    parameter int N_IN      = 5,
    parameter int M_TEST    = 2,
    parameter int N_TAGS    = 8,
    parameter int IMG_BYTES = 32,
    parameter int NETS      = 2
) (
    input  wire logic                           clock,
    input  wire logic                           nrst,
    // apb slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [7:0]                     paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // status sources
    input  wire logic                           in_pwr_fault,
    input  wire logic                           out_pwr_fault,
    input  wire logic [NETS-1:0]                std_conn_est,
    input  wire logic [NETS-1:0]                std_conn_err,
    input  wire logic [N_IN*8-1:0]              in_stat,
    input  wire logic [7:0]                     out_stat,
    input  wire logic [M_TEST*8-1:0]            test_stat,
    input  wire logic [N_IN*8-1:0]              in_mon,
    input  wire logic [7:0]                     out_mon,
    input  wire logic [N_TAGS*32-1:0]           tag_data,
    // image out
    output logic      [IMG_BYTES*8-1:0]         image_data,
    output logic      [$clog2(IMG_BYTES+1)-1:0] image_len,
    output logic      [7:0]                     gen_status,
    output logic                                irq
);
    import rio_image_pkg::*;

    localparam int LW   = $clog2(IMG_BYTES + 1);
    localparam int TCW  = $clog2(N_TAGS + 1);
    localparam int CAND = 3 + 2 * N_IN + M_TEST + 4 * N_TAGS;

    // tag size code to byte count; an unused code counts as one byte
    function automatic int tag_bytes(input logic [1:0] code);
        unique case (code)
            TSZ_WORD:  tag_bytes = 2;
            TSZ_DWORD: tag_bytes = 4;
            default:   tag_bytes = 1;
        endcase
    endfunction

    logic [CTRL_W-1:0]        ctrl_r;
    logic [31:0]              sel_r;
    logic [TCW-1:0]           tag_cnt_r;
    logic [N_TAGS*2-1:0]      tag_size_r;
    logic [IRQ_W-1:0]         irq_stat_r;
    logic [IRQ_W-1:0]         irq_mask_r;
    logic [31:0]              prdata_r;
    logic                     pready_r;
    logic                     pslverr_r;
    logic                     irq_r;
    logic [IMG_BYTES*8-1:0]   image_r;
    logic [IMG_BYTES*8-1:0]   image_nxt;
    logic [LW-1:0]            len_r;
    logic [LW-1:0]            len_nxt;
    logic                     ovf_r;
    logic                     ovf_nxt;
    logic [2:0]               gs_prev_r;
    logic [CAND*8-1:0]        cand;
    logic [CAND-1:0]          cand_vld;
    logic [IRQ_W-1:0]         irq_ev;
    logic [31:0]              rd_val;
    logic                     rd_hit;
    logic                     setup_ph;
    logic                     access_done;
    logic                     irq_rd_clr;

    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign irq        = irq_r;
    assign image_data = image_r;
    assign image_len  = len_r;

    // general status bits 0..2
    gen_status_unit #(
        .NETS          (NETS)
    ) u_gen_status (
        .clock         (clock),
        .nrst          (nrst),
        .in_pwr_fault  (in_pwr_fault),
        .in_used       (ctrl_r[CTRL_IN_USED]),
        .out_pwr_fault (out_pwr_fault),
        .out_used      (ctrl_r[CTRL_OUT_USED]),
        .std_conn_est  (std_conn_est),
        .std_conn_err  (std_conn_err),
        .gen_status_r  (gen_status)
    );

    // candidate bytes in image order; the packer drops unselected ones
    always_comb begin
        int k;
        k        = 0;
        cand     = '0;
        cand_vld = '0;
        cand[k*8 +: 8] = gen_status;
        cand_vld[k]    = ctrl_r[CTRL_GEN_SEL];
        k = k + 1;
        for (int i = 0; i < N_IN; i++) begin
            cand[k*8 +: 8] = in_stat[i*8 +: 8];
            cand_vld[k]    = sel_r[SEL_IN_STAT_LSB + i];
            k = k + 1;
        end
        cand[k*8 +: 8] = out_stat;
        cand_vld[k]    = ctrl_r[CTRL_OUT_STAT];
        k = k + 1;
        for (int i = 0; i < M_TEST; i++) begin
            cand[k*8 +: 8] = test_stat[i*8 +: 8];
            cand_vld[k]    = sel_r[SEL_TEST_LSB + i];
            k = k + 1;
        end
        for (int i = 0; i < N_IN; i++) begin
            cand[k*8 +: 8] = in_mon[i*8 +: 8];
            cand_vld[k]    = sel_r[SEL_IN_MON_LSB + i];
            k = k + 1;
        end
        cand[k*8 +: 8] = out_mon;
        cand_vld[k]    = ctrl_r[CTRL_OUT_MON];
        k = k + 1;
        // each tag owns four slots; only its sized low bytes are valid
        for (int t = 0; t < N_TAGS; t++) begin
            for (int j = 0; j < 4; j++) begin
                cand[k*8 +: 8] = tag_data[t*32 + j*8 +: 8];
                cand_vld[k]    = (t < int'(tag_cnt_r)) &&
                                 (j < tag_bytes(tag_size_r[t*2 +: 2]));
                k = k + 1;
            end
        end
    end

    // compaction: each valid byte goes to the next free position until IMG_BYTES are placed
    always_comb begin
        int cnt;
        cnt       = 0;
        image_nxt = '0;
        ovf_nxt   = 1'b0;
        for (int i = 0; i < CAND; i++) begin
            if (cand_vld[i]) begin
                if (cnt < IMG_BYTES) begin
                    image_nxt[cnt*8 +: 8] = cand[i*8 +: 8];
                    cnt = cnt + 1;
                end else begin
                    ovf_nxt = 1'b1;   // bytes past the image end are dropped
                end
            end
        end
        len_nxt = LW'(cnt);
    end

    // image register, rebuilt every cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            image_r <= '0;
            len_r   <= '0;
            ovf_r   <= 1'b0;
        end else begin
            image_r <= image_nxt;
            len_r   <= len_nxt;
            ovf_r   <= ovf_nxt;
        end
    end

    // apb phase decode
    assign setup_ph    = psel & ~penable;
    assign access_done = psel & penable & pready_r;
    assign irq_rd_clr  = access_done & ~pwrite & (paddr == OFS_IRQ_STAT);

    // read mux, sampled in the setup cycle so the access phase needs no wait
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (paddr)
            OFS_CTRL:     rd_val[CTRL_W-1:0]    = ctrl_r;
            OFS_SEL:      rd_val                = sel_r;
            OFS_TAG_CNT:  rd_val[TCW-1:0]       = tag_cnt_r;
            OFS_TAG_SIZE: rd_val[N_TAGS*2-1:0]  = tag_size_r;
            OFS_STATUS: begin
                rd_val[STAT_GEN_LSB +: 8]  = gen_status;
                rd_val[STAT_LEN_LSB +: LW] = len_r;
                rd_val[STAT_OVF_BIT]       = ovf_r;
            end
            OFS_IRQ_STAT: rd_val[IRQ_W-1:0]     = irq_stat_r;
            OFS_IRQ_MASK: rd_val[IRQ_W-1:0]     = irq_mask_r;
            default:      rd_hit                = 1'b0;
        endcase
    end

    // response flops: zero wait states, error on unmapped address
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= 1'b1;
            if (setup_ph) begin
                prdata_r  <= pwrite ? 32'h0000_0000 : rd_val;
                pslverr_r <= ~rd_hit;
            end
        end
    end

    // configuration writes take effect at the completing access edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_r     <= CTRL_RST;
            sel_r      <= SEL_RST;
            tag_cnt_r  <= '0;
            tag_size_r <= '0;
            irq_mask_r <= IRQ_MASK_RST;
        end else if (access_done && pwrite) begin
            unique case (paddr)
                OFS_CTRL:     ctrl_r     <= pwdata[CTRL_W-1:0];
                OFS_SEL: begin
                    // unimplemented select bits are kept at zero
                    sel_r <= '0;
                    sel_r[SEL_IN_STAT_LSB +: N_IN]  <= pwdata[SEL_IN_STAT_LSB +: N_IN];
                    sel_r[SEL_TEST_LSB +: M_TEST]   <= pwdata[SEL_TEST_LSB +: M_TEST];
                    sel_r[SEL_IN_MON_LSB +: N_IN]   <= pwdata[SEL_IN_MON_LSB +: N_IN];
                end
                OFS_TAG_CNT: begin
                    // clamp so a tag count never reaches past the table
                    if (pwdata > 32'(N_TAGS)) begin
                        tag_cnt_r <= TCW'(N_TAGS);
                    end else begin
                        tag_cnt_r <= pwdata[TCW-1:0];
                    end
                end
                OFS_TAG_SIZE: tag_size_r <= pwdata[N_TAGS*2-1:0];
                OFS_IRQ_MASK: irq_mask_r <= pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // events: rising edges of the fault bits and of image overflow
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gs_prev_r <= 3'h0;
        end else begin
            gs_prev_r <= gen_status[2:0];
        end
    end

    always_comb begin
        irq_ev              = '0;
        irq_ev[IRQ_IN_PWR]  = gen_status[GS_IN_PWR]  & ~gs_prev_r[GS_IN_PWR];
        irq_ev[IRQ_OUT_PWR] = gen_status[GS_OUT_PWR] & ~gs_prev_r[GS_OUT_PWR];
        irq_ev[IRQ_STD_ERR] = gen_status[GS_STD_ERR] & ~gs_prev_r[GS_STD_ERR];
        irq_ev[IRQ_OVF]     = ovf_nxt & ~ovf_r;
    end

    // a read clears only the bits it reported at setup, so an event that lands
    // between setup and access is kept; a new event wins over the clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(irq_rd_clr ? prdata_r[IRQ_W-1:0] : '0)) | irq_ev;
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule

// file: dv/rio_image_asserts.sv
// Purpose: port-level checks for the remote I/O image assembler
// Assumes: sees only top-level ports; one clock domain
// Notes:   cfg registers are internal, so supply bits are checked one way only
`timescale 1ns/1ps
module rio_image_asserts
    import rio_image_pkg::*;
#(
    parameter int NETS      = 2,
    parameter int IMG_BYTES = 32
) (
    input wire logic                           clock,
    input wire logic                           nrst,
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic [7:0]                     paddr,
    input wire logic                           pready,
    input wire logic                           pslverr,
    input wire logic                           in_pwr_fault,
    input wire logic                           out_pwr_fault,
    input wire logic [NETS-1:0]                std_conn_est,
    input wire logic [NETS-1:0]                std_conn_err,
    input wire logic [IMG_BYTES*8-1:0]         image_data,
    input wire logic [$clog2(IMG_BYTES+1)-1:0] image_len,
    input wire logic [7:0]                     gen_status,
    input wire logic                           irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // reset must not leave stale image or status visible to the master
    chk_rst_zero: assert property (disable iff (1'b0) !nrst |-> gen_status == 8'h00
        && image_len == '0 && !irq && !pready) else $error("outputs not zero in reset");
    chk_in_pwr: assert property (gen_status[GS_IN_PWR] |-> $past(in_pwr_fault))
        else $error("input supply bit without fault");
    chk_out_pwr: assert property (gen_status[GS_OUT_PWR] |-> $past(out_pwr_fault))
        else $error("output supply bit without fault");
    chk_std_set: assert property ($past(nrst) &&
        (|($past(std_conn_est) & $past(std_conn_err))) |-> gen_status[GS_STD_ERR])
        else $error("std error bit missing");
    chk_std_clear: assert property ($past(nrst) &&
        !(|($past(std_conn_est) & $past(std_conn_err))) |-> !gen_status[GS_STD_ERR])
        else $error("std error bit without error");
    chk_len_bound: assert property (image_len <= IMG_BYTES)
        else $error("image length beyond buffer");
    chk_empty_zero: assert property (image_len == '0 |-> image_data == '0)
        else $error("stray bytes in empty image");
    chk_pready_up: assert property ($past(nrst) |-> pready)
        else $error("pready low after reset");
    chk_err_map: assert property (psel && !penable && paddr[1:0] == 2'h0
        |=> pslverr == ($past(paddr) > OFS_IRQ_MASK)) else $error("pslverr wrong for address");

    cover property (psel && penable && pslverr);
    cover property (gen_status[GS_STD_ERR]);
    cover property (irq);
    cover property (image_len == IMG_BYTES);
endmodule

bind rio_image_assembler rio_image_asserts #(.NETS(NETS), .IMG_BYTES(IMG_BYTES)) u_chk (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .in_pwr_fault(in_pwr_fault),
    .out_pwr_fault(out_pwr_fault), .std_conn_est(std_conn_est),
    .std_conn_err(std_conn_err), .image_data(image_data), .image_len(image_len),
    .gen_status(gen_status), .irq(irq));

// file: dv/plc_image_reader.sv
// Purpose: network master model that polls the remote I/O input image
// Assumes: image is read whole once per poll
// Notes:   copy freezes between polls, like a scan-based controller
`timescale 1ns/1ps
module plc_image_reader #(
    parameter int IMG_BYTES = 32
) (
    input  wire logic                           clock,
    input  wire logic                           poll,
    input  wire logic [IMG_BYTES*8-1:0]         image_data,
    input  wire logic [$clog2(IMG_BYTES+1)-1:0] image_len,
    output logic      [IMG_BYTES*8-1:0]         got_img,
    output logic      [$clog2(IMG_BYTES+1)-1:0] got_len
);
    // one snapshot per poll, so a half-updated image is never mixed in
    always_ff @(posedge clock) begin
        if (poll) begin
            got_img <= image_data;
            got_len <= image_len;
        end
    end
endmodule

// file: dv/rio_image_assembler_tb.sv
// Purpose: self-checking bench for the remote I/O image assembler
// Assumes: default parameters; APB slave with zero wait states
// Notes:   random configs with seed, plus fixed layouts; expectations built here
`timescale 1ns/1ps
module rio_image_assembler_tb;
    import rio_image_pkg::*;
    logic         clock, nrst, psel, penable, pwrite, pready, pslverr, err, poll, irq;
    logic         in_pwr_fault, out_pwr_fault;
    logic [7:0]   paddr, out_stat, out_mon, gen_status;
    logic [31:0]  pwdata, prdata, rd, sel, tsz;
    logic [1:0]   std_conn_est, std_conn_err;
    logic [39:0]  in_stat, in_mon;
    logic [15:0]  test_stat;
    logic [255:0] tag_data, image_data, got_img, exp_img;
    logic [5:0]   image_len, got_len;
    logic [4:0]   ctrl;
    int           tcnt, exp_len, bad_count, compares;

    rio_image_assembler dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_pwr_fault(in_pwr_fault), .out_pwr_fault(out_pwr_fault),
        .std_conn_est(std_conn_est), .std_conn_err(std_conn_err), .in_stat(in_stat),
        .out_stat(out_stat), .test_stat(test_stat), .in_mon(in_mon), .out_mon(out_mon),
        .tag_data(tag_data), .image_data(image_data), .image_len(image_len),
        .gen_status(gen_status), .irq(irq));
    plc_image_reader u_plc (.clock(clock), .poll(poll), .image_data(image_data),
        .image_len(image_len), .got_img(got_img), .got_len(got_len));

    always #10 clock = ~clock;

    // one APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // no own limit: a slave that never answers is caught by the watchdog
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic chk(input logic [255:0] got, input logic [255:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    function automatic logic [7:0] gs_exp();
        return {5'h00, |(std_conn_est & std_conn_err), out_pwr_fault & ctrl[CTRL_OUT_USED],
                in_pwr_fault & ctrl[CTRL_IN_USED]};
    endfunction

    // reference packing: every slot in fixed order, unselected ones skipped
    function automatic void build();
        logic [7:0] q[$];
        int         w;
        exp_img = '0;
        if (ctrl[CTRL_GEN_SEL]) q.push_back(gs_exp());
        for (int i = 0; i < 5; i++) if (sel[i]) q.push_back(in_stat[i*8+:8]);
        if (ctrl[CTRL_OUT_STAT]) q.push_back(out_stat);
        for (int i = 0; i < 2; i++) if (sel[8+i]) q.push_back(test_stat[i*8+:8]);
        for (int i = 0; i < 5; i++) if (sel[16+i]) q.push_back(in_mon[i*8+:8]);
        if (ctrl[CTRL_OUT_MON]) q.push_back(out_mon);
        for (int t = 0; t < tcnt; t++) begin
            w = (tsz[2*t+:2] == TSZ_WORD) ? 2 : (tsz[2*t+:2] == TSZ_DWORD) ? 4 : 1;
            for (int b = 0; b < w; b++) q.push_back(tag_data[t*32+b*8+:8]);
        end
        exp_len = (q.size() > 32) ? 32 : q.size();
        for (int i = 0; i < exp_len; i++) exp_img[i*8+:8] = q[i];
    endfunction

    // program the layout, let the image settle, then poll it
    task automatic run_image();
        apb(1'b1, OFS_CTRL, 32'(ctrl));
        apb(1'b1, OFS_SEL, sel);
        apb(1'b1, OFS_TAG_CNT, 32'(tcnt));
        apb(1'b1, OFS_TAG_SIZE, tsz);
        repeat (2) @(posedge clock);
        poll <= 1'b1;
        @(posedge clock);
        poll <= 1'b0;
        @(posedge clock);
        build();
        chk(got_img, exp_img, "image bytes");
        chk(got_len, 256'(exp_len), "image length");
        chk(gen_status, gs_exp(), "general status");
    endtask

    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog, far beyond the roughly 720 cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        summarize();
    end

    initial begin
        {clock, nrst, psel, penable, pwrite, poll, in_pwr_fault, out_pwr_fault} = 8'h00;
        {paddr, out_stat, out_mon, pwdata, std_conn_est, std_conn_err} = '0;
        {in_stat, in_mon, test_stat, tag_data} = '0;
        bad_count = 0;
        compares = 0;
        void'($urandom(32'h792c));
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            chk({err, rd}, '0, "reset value");
        end
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk({err, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
        for (int it = 0; it < 40; it++) begin
            {in_pwr_fault, out_pwr_fault, std_conn_est, std_conn_err} <= 6'($urandom);
            in_stat <= 40'({$urandom, $urandom});
            in_mon <= 40'({$urandom, $urandom});
            {test_stat, out_stat, out_mon} <= $urandom;
            for (int t = 0; t < 8; t++) tag_data[t*32+:32] <= $urandom;
            ctrl = 5'($urandom);
            sel = $urandom & 32'h001F_031F;
            tcnt = $urandom_range(0, 3);
            tsz = $urandom;
            // fixed layouts: two inputs plus byte and dword tag; sparse inputs with monitors
            if (it == 0) {ctrl, sel, tcnt, tsz} = {5'h02, 32'h0000_0003, 32'd2, 32'h0000_0008};
            if (it == 1) {ctrl, sel, tcnt, tsz} = {5'h06, 32'h0015_0015, 32'd2, 32'h0000_0000};
            if (it == 2) {ctrl, sel, tcnt, tsz} = {5'h19, 32'h0000_0001, 32'd1, 32'h0000_0001};
            if (it == 3) {ctrl, sel, tcnt, tsz} = {5'h00, 32'h0000_0000, 32'd8, 32'h0000_FFFF};
            run_image();
        end
        // unmasked supply event raises irq; a status read drops it
        in_pwr_fault <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h0000_0008);
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
        chk(irq, 1'b0, "irq idle");
        in_pwr_fault <= 1'b1;
        repeat (4) @(posedge clock);
        chk(irq, 1'b1, "irq on supply fault");
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0001, "irq status");
        repeat (2) @(posedge clock);
        chk(irq, 1'b0, "irq after clear");
        // too much data: truncated image, overflow flagged but masked
        {ctrl, sel, tcnt, tsz} = {5'h07, 32'h001F_031F, 32'd8, 32'h0000_AAAA};
        run_image();
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(rd[STAT_OVF_BIT], 1'b1, "overflow flag");
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk({irq, rd[IRQ_OVF]}, 2'b01, "masked overflow event");
        summarize();
    end
endmodule
